// *** core/quasi_port_cfg.svh ***
`ifndef QUASI_PORT_CFG_SVH
`define QUASI_PORT_CFG_SVH

// Port register reset value: every pin weak-high.
`define PORT_RESET       8'hff
// Software reset sequence.
`define GC_ADDR          7'h00
`define GC_RESET_BYTE    8'h06
// Default slave address of the device end.
`define DEV_ADDR_DEFAULT 7'h20
// Bit positions inside the device's synchroniser bundle.
`define SYN_RST          10
`define SYN_SCL          9
`define SYN_SDA          8
// Bit positions inside the controller's synchroniser bundle.
`define HSYN_INT         1
`define HSYN_SDA         0
// Controller register offsets.
`define REG_TX           3'h0
`define REG_CMD          3'h1
`define REG_STATUS       3'h2
`define REG_RX           3'h3
`define REG_RSTCTL       3'h4
// Command register fields.
`define CMD_START        0
`define CMD_STOP         1
`define CMD_WRITE        2
`define CMD_READ         3
`define CMD_NACK         4
// Status register fields.
`define ST_BUSY          0
`define ST_ACK           1
`define ST_INT           2
// Timing.
`define CLK_PERIOD_NS    25
`define SCL_PERIOD_NS    1000
`define SCL_QUARTER_CYC  (`SCL_PERIOD_NS / (4 * `CLK_PERIOD_NS))

`endif

// *** core/quasi_port_dev.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "quasi_port_cfg.svh"
module quasi_port_dev
	import quasi_port_pkg::*;
#(
	parameter logic [6:0] SLAVE_ADDR = `DEV_ADDR_DEFAULT
) (
	input  wire logic         clk,        // System clock.
	input  wire logic         nrst,       // Asynchronous reset, active low.
	quasi_port_if.device      link,       // Bus, pins and interrupt.
	output logic       [7:0]  port_value, // Latched port register.
	output logic              busy        // Bus machine is not idle, address phase included.
);

	generate
		if (SLAVE_ADDR == `GC_ADDR) begin : g_bad_addr
			$error("SLAVE_ADDR must differ from the general call address");
		end
	endgenerate

	localparam dev_regs_t DEV_RESET = '{
		sy1: '1, sy2: '1, sy3: '1, filt: '1,
		state: D_IDLE, cnt: 4'h0, shift: 8'h00,
		is_read: 1'b0, is_gc: 1'b0, gc_seen: 1'b0, gc_ok: 1'b0,
		mack: 1'b0, port_value: `PORT_RESET, sink: ~`PORT_RESET,
		boost: 8'h00, ref_value: `PORT_RESET,
		sda_oe: 1'b0, int_oe: 1'b0, busy: 1'b0
	};

	dev_regs_t st;
	dev_regs_t next_st;

	// Return to power-up state but keep the synchronisers running.
	function automatic dev_regs_t soft_reset(input dev_regs_t s);
		dev_regs_t r;
		r            = DEV_RESET;
		r.sy1        = s.sy1;
		r.sy2        = s.sy2;
		r.sy3        = s.sy3;
		r.filt       = s.filt;
		return r;
	endfunction : soft_reset

	always_comb begin
		logic [10:0] agree;
		logic        scl_rise;
		logic        scl_fall;
		logic        start_c;
		logic        stop_c;
		logic        sda_now;
		logic [7:0]  pins;
		agree    = 11'h000;
		scl_rise = 1'b0;
		scl_fall = 1'b0;
		start_c  = 1'b0;
		stop_c   = 1'b0;
		sda_now  = 1'b0;
		pins     = 8'h00;
		next_st  = st;

		// Three stages; a change counts once stages two and three agree.
		next_st.sy1 = {link.rst_pin_n, link.scl, link.sda, link.port_pins};
		next_st.sy2 = st.sy1;
		next_st.sy3 = st.sy2;
		agree        = ~(st.sy2 ^ st.sy3);
		next_st.filt = (st.sy2 & agree) | (st.filt & ~agree);

		scl_rise = ~st.filt[`SYN_SCL] & next_st.filt[`SYN_SCL];
		scl_fall = st.filt[`SYN_SCL] & ~next_st.filt[`SYN_SCL];
		start_c  = st.filt[`SYN_SCL] & next_st.filt[`SYN_SCL] &
			st.filt[`SYN_SDA] & ~next_st.filt[`SYN_SDA];
		stop_c   = st.filt[`SYN_SCL] & next_st.filt[`SYN_SCL] &
			~st.filt[`SYN_SDA] & next_st.filt[`SYN_SDA];
		sda_now  = st.filt[`SYN_SDA];
		pins     = st.filt[7:0];

		case (st.state)
			D_ADDR, D_WDATA, D_GDATA: begin
				if (scl_rise) begin
					next_st.shift = {st.shift[6:0], sda_now};
					next_st.cnt   = st.cnt + 4'h1;
				end else if (scl_fall && st.cnt == 4'h8) begin
					next_st.cnt = 4'h0;
					if (st.state == D_ADDR) begin
						next_st.is_read = st.shift[0];
						next_st.is_gc   = st.shift[7:1] == `GC_ADDR;
						if (st.shift[7:1] == SLAVE_ADDR ||
							(st.shift[7:1] == `GC_ADDR && !st.shift[0])) begin
							next_st.state  = D_AACK;
							next_st.sda_oe = 1'b1;
						end else begin
							next_st.state = D_IDLE;
						end
					end else if (st.state == D_WDATA) begin
						next_st.state  = D_WACK;
						next_st.sda_oe = 1'b1;
					end else begin
						// Only a first byte of 06h is acknowledged.
						next_st.gc_seen = 1'b1;
						if (!st.gc_seen && st.shift == `GC_RESET_BYTE) begin
							next_st.gc_ok  = 1'b1;
							next_st.state  = D_GACK;
							next_st.sda_oe = 1'b1;
						end else begin
							next_st.gc_ok = 1'b0;
							next_st.state = D_IDLE;
						end
					end
				end
			end
			D_AACK: begin
				if (scl_fall) begin
					next_st.sda_oe = 1'b0;
					next_st.cnt    = 4'h0;
					if (st.is_read) begin
						// Read pulse: capture pins and clear the interrupt.
						next_st.shift     = pins;
						next_st.ref_value = pins;
						next_st.sda_oe    = ~pins[7];
						next_st.state     = D_RDATA;
					end else if (st.is_gc) begin
						next_st.state = D_GDATA;
					end else begin
						next_st.state = D_WDATA;
					end
				end
			end
			D_WACK: begin
				if (scl_rise) begin
					// The byte reaches the pins as SCL rises in the ack bit.
					next_st.port_value = st.shift;
					next_st.sink       = ~st.shift;
					next_st.boost      = st.shift;
				end else if (scl_fall) begin
					next_st.sda_oe    = 1'b0;
					next_st.boost     = 8'h00;
					next_st.ref_value = pins;
					next_st.state     = D_WDATA;
				end
			end
			D_GACK: begin
				if (scl_fall) begin
					next_st.sda_oe = 1'b0;
					next_st.state  = D_GDATA;
				end
			end
			D_RDATA: begin
				if (scl_rise) begin
					next_st.cnt = st.cnt + 4'h1;
				end else if (scl_fall) begin
					if (st.cnt == 4'h8) begin
						next_st.cnt    = 4'h0;
						next_st.sda_oe = 1'b0;
						next_st.state  = D_RACK;
					end else begin
						next_st.shift  = {st.shift[6:0], 1'b0};
						next_st.sda_oe = ~st.shift[6];
					end
				end
			end
			D_RACK: begin
				if (scl_rise) begin
					next_st.mack = ~sda_now;
				end else if (scl_fall) begin
					if (st.mack) begin
						// Master asked for another fresh sample.
						next_st.shift     = pins;
						next_st.ref_value = pins;
						next_st.sda_oe    = ~pins[7];
						next_st.state     = D_RDATA;
					end else begin
						next_st.state = D_IDLE;
					end
				end
			end
			D_IDLE: begin
				next_st.sda_oe = 1'b0;
			end
			default: begin
				next_st.state = D_IDLE;
			end
		endcase

		if (start_c) begin
			// A repeated start also cancels a pending software reset.
			next_st.state   = D_ADDR;
			next_st.cnt     = 4'h0;
			next_st.sda_oe  = 1'b0;
			next_st.boost   = 8'h00;
			next_st.gc_ok   = 1'b0;
			next_st.gc_seen = 1'b0;
		end else if (stop_c) begin
			// The stop's own SCL rise has already counted as one bit.
			if (st.gc_ok && st.state == D_GDATA && st.cnt <= 4'h1) begin
				next_st = soft_reset(next_st);
			end else begin
				next_st.state  = D_IDLE;
				next_st.sda_oe = 1'b0;
				next_st.boost  = 8'h00;
				next_st.gc_ok  = 1'b0;
			end
		end

		if (!st.filt[`SYN_RST]) begin
			next_st = soft_reset(next_st);
		end

		// Any difference from the last captured value pulls the line low.
		next_st.int_oe = pins != next_st.ref_value;
		next_st.busy   = next_st.state != D_IDLE;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st <= DEV_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign link.sda_d_o   = 1'b0;
	assign link.sda_d_oe  = st.sda_oe;
	assign link.pin_o     = 8'h00;
	assign link.pin_oe    = st.sink;
	assign link.pin_boost = st.boost;
	assign link.int_o     = 1'b0;
	assign link.int_oe    = st.int_oe;
	assign port_value     = st.port_value;
	assign busy           = st.busy;

endmodule : quasi_port_dev
`default_nettype wire

// *** core/quasi_port_host.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "quasi_port_cfg.svh"
module quasi_port_host
	import quasi_port_pkg::*;
#(
	parameter int QUARTER = `SCL_QUARTER_CYC
) (
	input  wire logic        clk,   // System clock.
	input  wire logic        nrst,  // Asynchronous reset, active low.
	quasi_port_if.host       link,  // Bus side.
	input  wire logic [2:0]  addr,  // Register address.
	input  wire logic [7:0]  wdata, // Write data.
	input  wire logic        wr,    // Write strobe.
	input  wire logic        rd,    // Read strobe.
	output logic      [7:0]  rdata  // Read data, cycle after rd.
);

	// The device filters SCL through three stages and a filter register, so a quarter bit
	// shorter than those four would race its edge detection.
	generate
		if (QUARTER < 4 || QUARTER > 255) begin : g_bad_quarter
			$error("QUARTER must lie between 4 and 255");
		end
	endgenerate

	localparam logic [7:0] QEND = 8'(QUARTER - 1);

	localparam host_regs_t HOST_RESET = '{
		sy1: '1, sy2: '1, sy3: '1, filt: '1,
		phase: H_IDLE, q: 2'h0, qcnt: 8'h00, bit_i: 4'h0,
		tx: 8'h00, tx_shift: 8'h00, rx: 8'h00, cmd: 5'h00,
		ack_rcv: 1'b0, scl_oe: 1'b0, sda_oe: 1'b0,
		rst_pin_n: 1'b1, rdata: 8'h00
	};

	host_regs_t st;
	host_regs_t next_st;

	function automatic host_phase_t after_byte(input logic [4:0] c);
		return c[`CMD_STOP] ? H_STOP : H_IDLE;
	endfunction : after_byte

	always_comb begin
		logic [1:0] agree;
		logic       tick;
		logic       sda_now;
		agree   = 2'h0;
		tick    = 1'b0;
		sda_now = 1'b0;
		next_st = st;

		next_st.sy1  = {link.int_n, link.sda};
		next_st.sy2  = st.sy1;
		next_st.sy3  = st.sy2;
		agree        = ~(st.sy2 ^ st.sy3);
		next_st.filt = (st.sy2 & agree) | (st.filt & ~agree);
		sda_now      = st.filt[`HSYN_SDA];

		tick = st.qcnt == QEND;
		if (st.phase != H_IDLE) begin
			next_st.qcnt = tick ? 8'h00 : st.qcnt + 8'h01;
			if (tick) begin
				next_st.q = st.q + 2'h1;
			end
		end

		case (st.phase)
			H_START: begin
				if (tick) begin
					case (st.q)
						2'h0: next_st.sda_oe = 1'b0;
						2'h1: next_st.scl_oe = 1'b0;
						2'h2: next_st.sda_oe = 1'b1;
						default: begin
							next_st.scl_oe = 1'b1;
							next_st.bit_i  = 4'h0;
							next_st.phase  = (st.cmd[`CMD_WRITE] ||
								st.cmd[`CMD_READ]) ? H_BIT : after_byte(st.cmd);
						end
					endcase
				end
			end
			H_BIT: begin
				if (tick) begin
					case (st.q)
						2'h0: begin
							if (st.bit_i == 4'h8) begin
								next_st.sda_oe = st.cmd[`CMD_READ] &
									~st.cmd[`CMD_NACK];
							end else begin
								next_st.sda_oe = st.cmd[`CMD_WRITE] &
									~st.tx_shift[7];
							end
						end
						2'h1: next_st.scl_oe = 1'b0;
						2'h2: begin
							if (st.bit_i == 4'h8) begin
								if (st.cmd[`CMD_WRITE]) begin
									next_st.ack_rcv = ~sda_now;
								end
							end else if (st.cmd[`CMD_READ]) begin
								next_st.rx = {st.rx[6:0], sda_now};
							end
						end
						default: begin
							next_st.scl_oe   = 1'b1;
							next_st.tx_shift = {st.tx_shift[6:0], 1'b0};
							next_st.bit_i    = st.bit_i + 4'h1;
							if (st.bit_i == 4'h8) begin
								next_st.phase = after_byte(st.cmd);
							end
						end
					endcase
				end
			end
			H_STOP: begin
				if (tick) begin
					case (st.q)
						2'h0: next_st.sda_oe = 1'b1;
						2'h1: next_st.scl_oe = 1'b0;
						2'h2: next_st.sda_oe = 1'b0;
						default: next_st.phase = H_IDLE;
					endcase
				end
			end
			H_IDLE: begin
				next_st.q    = 2'h0;
				next_st.qcnt = 8'h00;
			end
			default: begin
				next_st.phase = H_IDLE;
			end
		endcase

		if (wr) begin
			case (addr)
				`REG_TX: next_st.tx = wdata;
				`REG_RSTCTL: next_st.rst_pin_n = ~wdata[0];
				`REG_CMD: begin
					// Commands arriving while busy are dropped.
					if (st.phase == H_IDLE) begin
						next_st.cmd      = wdata[4:0];
						next_st.tx_shift = st.tx;
						next_st.bit_i    = 4'h0;
						next_st.q        = 2'h0;
						next_st.qcnt     = 8'h00;
						if (wdata[`CMD_START]) begin
							next_st.phase = H_START;
						end else if (wdata[`CMD_WRITE] || wdata[`CMD_READ]) begin
							next_st.phase = H_BIT;
						end else if (wdata[`CMD_STOP]) begin
							next_st.phase = H_STOP;
						end
					end
				end
				default: begin
				end
			endcase
		end

		if (rd) begin
			case (addr)
				`REG_TX: next_st.rdata = st.tx;
				`REG_STATUS: next_st.rdata = {5'h00, ~st.filt[`HSYN_INT],
					st.ack_rcv, st.phase != H_IDLE};
				`REG_RX: next_st.rdata = st.rx;
				`REG_RSTCTL: next_st.rdata = {7'h00, ~st.rst_pin_n};
				default: next_st.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st <= HOST_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign link.scl_o     = 1'b0;
	assign link.scl_oe    = st.scl_oe;
	assign link.sda_m_o   = 1'b0;
	assign link.sda_m_oe  = st.sda_oe;
	assign link.rst_pin_n = st.rst_pin_n;
	assign rdata          = st.rdata;

endmodule : quasi_port_host
`default_nettype wire

// *** core/quasi_port_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface quasi_port_if;
	logic       scl_o;
	logic       scl_oe;
	logic       sda_m_o;
	logic       sda_m_oe;
	logic       sda_d_o;
	logic       sda_d_oe;
	logic       scl;
	logic       sda;
	logic [7:0] pin_o;
	logic [7:0] pin_oe;
	logic [7:0] pin_boost;
	logic [7:0] ext_pull_low;
	logic [7:0] port_pins;
	logic       int_o;
	logic       int_oe;
	logic       int_n;
	logic       rst_pin_n;

	// Open-drain lines: any enabled driver pulls the wire low.
	assign scl       = ~scl_oe;
	assign sda       = ~(sda_m_oe | sda_d_oe);
	assign port_pins = ~(pin_oe | ext_pull_low);
	assign int_n     = ~int_oe;

	modport device (
		input  scl, sda, port_pins, rst_pin_n,
		output sda_d_o, sda_d_oe, pin_o, pin_oe, pin_boost, int_o, int_oe
	);
	modport host (
		input  scl, sda, int_n,
		output scl_o, scl_oe, sda_m_o, sda_m_oe, rst_pin_n
	);
endinterface : quasi_port_if
`default_nettype wire

// *** core/quasi_port_pkg.sv ***
`default_nettype none
package quasi_port_pkg;

	typedef enum logic [3:0] {
		D_IDLE, D_ADDR, D_AACK, D_WDATA, D_WACK,
		D_RDATA, D_RACK, D_GDATA, D_GACK
	} dev_state_t;

	typedef struct packed {
		logic [10:0] sy1;
		logic [10:0] sy2;
		logic [10:0] sy3;
		logic [10:0] filt;
		dev_state_t  state;
		logic [3:0]  cnt;
		logic [7:0]  shift;
		logic        is_read;
		logic        is_gc;
		logic        gc_seen;
		logic        gc_ok;
		logic        mack;
		logic [7:0]  port_value;
		logic [7:0]  sink;
		logic [7:0]  boost;
		logic [7:0]  ref_value;
		logic        sda_oe;
		logic        int_oe;
		logic        busy;
	} dev_regs_t;

	typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} host_phase_t;

	typedef struct packed {
		logic [1:0]  sy1;
		logic [1:0]  sy2;
		logic [1:0]  sy3;
		logic [1:0]  filt;
		host_phase_t phase;
		logic [1:0]  q;
		logic [7:0]  qcnt;
		logic [3:0]  bit_i;
		logic [7:0]  tx;
		logic [7:0]  tx_shift;
		logic [7:0]  rx;
		logic [4:0]  cmd;
		logic        ack_rcv;
		logic        scl_oe;
		logic        sda_oe;
		logic        rst_pin_n;
		logic [7:0]  rdata;
	} host_regs_t;

endpackage : quasi_port_pkg
`default_nettype wire

// *** sim/quasi_port_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module quasi_port_assertions (
	input wire logic       clk,       // System clock.
	input wire logic       nrst,      // Asynchronous reset, active low.
	input wire logic       scl,       // Resolved bus clock.
	input wire logic       sda,       // Resolved bus data.
	input wire logic       sda_d_oe,  // Device pulls data low.
	input wire logic [7:0] pin_oe,    // Strong sinks on.
	input wire logic [7:0] pin_boost, // Strong pull-ups on.
	input wire logic [7:0] port_pins, // Resolved pin levels.
	input wire logic       int_n,     // Interrupt line, active low.
	input wire logic       rst_pin_n  // Reset pin, active low.
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	property p_reset_clean;
		$rose(nrst) |-> pin_oe == 8'h00 && pin_boost == 8'h00 && !sda_d_oe;
	endproperty
	a_reset_clean: assert property (p_reset_clean)
		else $error("port not clean after reset");

	property p_int_after_reset;
		$rose(nrst) && port_pins != 8'hff |-> ##[2:10] !int_n;
	endproperty
	a_int_after_reset: assert property (p_int_after_reset)
		else $error("low pin not flagged after reset");

	property p_pins_on_scl_high;
		$changed(pin_oe) |-> scl;
	endproperty
	a_pins_on_scl_high: assert property (p_pins_on_scl_high)
		else $error("sinks changed while clock low");

	// The boost must end soon after the clock high half, or it fights loads.
	property p_boost_brief;
		$rose(|pin_boost) |-> scl ##[1:24] pin_boost == 8'h00;
	endproperty
	a_boost_brief: assert property (p_boost_brief)
		else $error("pull-up boost not brief");

	property p_boost_no_sink;
		(pin_boost & pin_oe) == 8'h00;
	endproperty
	a_boost_no_sink: assert property (p_boost_no_sink)
		else $error("boost on a sinking pin");

	property p_sda_on_scl_low;
		$changed(sda_d_oe) |-> !scl;
	endproperty
	a_sda_on_scl_low: assert property (p_sda_on_scl_low)
		else $error("device data changed while clock high");

	property p_int_on_change;
		$changed(port_pins) && $stable(pin_oe) && scl && sda && int_n
			|-> ##[2:8] !int_n;
	endproperty
	a_int_on_change: assert property (p_int_on_change)
		else $error("pin edge not flagged");

	property p_rst_pin_hold;
		!rst_pin_n [*6] |-> pin_oe == 8'h00 && pin_boost == 8'h00 && !sda_d_oe;
	endproperty
	a_rst_pin_hold: assert property (p_rst_pin_hold)
		else $error("reset pin did not hold defaults");
endmodule : quasi_port_assertions
`default_nettype wire

// *** sim/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "quasi_port_cfg.svh"
module tb_top;
	localparam logic [7:0] AW = {`DEV_ADDR_DEFAULT, 1'b0};
	localparam logic [7:0] AR = {`DEV_ADDR_DEFAULT, 1'b1};
	logic       clk;
	logic       nrst;
	logic       wr;
	logic       rd;
	logic [2:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic [7:0] port_value;
	logic       busy;
	logic [7:0] st;
	logic [7:0] val;
	logic [7:0] e0;
	logic [7:0] e1;
	logic [7:0] sw_byte [4] = '{8'h06, 8'h07, 8'h06, 8'h06};
	int         i;
	int         j;
	int         seed;
	int         bad_count;
	int         cmp_count;

	quasi_port_if bus ();

	quasi_port_host #(.QUARTER(5)) i_quasi_port_host (.clk(clk), .nrst(nrst),
		.link(bus), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata));
	quasi_port_dev i_quasi_port_dev (.clk(clk), .nrst(nrst), .link(bus),
		.port_value(port_value), .busy(busy));
	quasi_port_assertions i_quasi_port_assertions (.clk(clk), .nrst(nrst),
		.scl(bus.scl), .sda(bus.sda), .sda_d_oe(bus.sda_d_oe),
		.pin_oe(bus.pin_oe), .pin_boost(bus.pin_boost),
		.port_pins(bus.port_pins), .int_n(bus.int_n),
		.rst_pin_n(bus.rst_pin_n));

	function automatic logic [7:0] seen(input logic [7:0] v, input logic [7:0] e);
		return v & ~e;
	endfunction : seen

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : end_of_test

	task automatic check(input string what, input logic [7:0] got, exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg

	task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : rd_reg

	// One controller command; the ack is only meaningful for written bytes.
	task automatic xfer(input logic [7:0] cmd, tx, input logic ack);
		int n = 0;
		wr_reg(`REG_TX, tx);
		wr_reg(`REG_CMD, cmd);
		do begin
			rd_reg(`REG_STATUS, st);
			n++;
		end while (st[`ST_BUSY] !== 1'b0 && n < 3000);
		if (st[`ST_BUSY] !== 1'b0) begin
			bad_count++;
			end_of_test();
		end
		if (cmd[`CMD_WRITE])
			check("ack", {7'h00, st[`ST_ACK]}, {7'h00, ack});
	endtask : xfer

	// The status bit lags the line through two synchronisers, so settle first.
	task automatic chk_int(input logic e);
		repeat (12) @(posedge clk);
		rd_reg(`REG_STATUS, st);
		check("int", {7'h00, st[`ST_INT]}, {7'h00, e});
	endtask : chk_int

	task automatic rd_pins(input logic [7:0] cmd, input logic [7:0] exp);
		xfer(cmd, 8'h00, 1'b0);
		rd_reg(`REG_RX, st);
		check("rx", st, exp);
	endtask : rd_pins

	task automatic set_ext(input logic [7:0] e);
		@(posedge clk);
		bus.ext_pull_low <= e;
	endtask : set_ext

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	initial begin
		repeat (80000) @(posedge clk);
		bad_count++;
		end_of_test();
	end

	initial begin
		seed = 32'hea1bdf23;
		nrst = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = 3'h0;
		wdata = 8'h00;
		bus.ext_pull_low = 8'h01;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		chk_int(1'b1);
		check("pins", bus.port_pins, 8'hfe);
		check("value", port_value, `PORT_RESET);
		rd_reg(3'h5, st);
		check("unmapped", st, 8'h00);
		xfer(8'h05, AR, 1'b1);
		rd_pins(8'h1a, 8'hfe);
		chk_int(1'b0);
		set_ext(8'h03);
		chk_int(1'b1);
		set_ext(8'h01);
		chk_int(1'b0);
		set_ext(8'h03);
		chk_int(1'b1);
		e0 = 8'h03;
		for (i = 0; i < 12; i++) begin
			xfer(8'h05, AW, 1'b1);
			for (j = 0; j <= i % 3; j++) begin
				val = 8'($random(seed));
				xfer((j == i % 3) ? 8'h06 : 8'h04, val, 1'b1);
				check("sink", bus.pin_oe, ~val);
				check("value", port_value, val);
			end
			chk_int(1'b0);
			e1 = 8'($random(seed));
			set_ext(e1);
			chk_int(seen(val, e1) != seen(val, e0));
			xfer(8'h05, AR, 1'b1);
			rd_pins(8'h08, seen(val, e1));
			e0 = 8'($random(seed));
			set_ext(e0);
			rd_pins(8'h08, seen(val, e1));
			rd_pins(8'h1a, seen(val, e0));
			chk_int(1'b0);
		end
		xfer(8'h05, AW, 1'b1);
		check("busy", {7'h00, busy}, 8'h01);
		xfer(8'h06, 8'hff, 1'b1);
		xfer(8'h05, AR, 1'b1);
		rd_pins(8'h1a, ~e0);
		set_ext(8'h00);
		xfer(8'h05, AW, 1'b1);
		xfer(8'h06, 8'h00, 1'b1);
		wr_reg(`REG_RSTCTL, 8'h01);
		repeat (8) @(posedge clk);
		check("sink", bus.pin_oe, 8'h00);
		check("busy", {7'h00, busy}, 8'h00);
		check("value", port_value, `PORT_RESET);
		wr_reg(`REG_RSTCTL, 8'h00);
		for (i = 0; i < 4; i++) begin
			xfer(8'h05, AW, 1'b1);
			xfer(8'h06, 8'h00, 1'b1);
			xfer(8'h05, {`GC_ADDR, 1'b0}, 1'b1);
			if (i < 2) begin
				xfer(8'h06, sw_byte[i], sw_byte[i] == `GC_RESET_BYTE);
			end else begin
				xfer(8'h04, sw_byte[i], 1'b1);
				if (i == 2) begin
					xfer(8'h06, sw_byte[i], 1'b0);
				end else begin
					xfer(8'h05, {`GC_ADDR, 1'b0}, 1'b1);
					xfer(8'h02, 8'h00, 1'b0);
				end
			end
			repeat (8) @(posedge clk);
			check("value", port_value, (i == 0) ? 8'hff : 8'h00);
		end
		xfer(8'h07, {7'h21, 1'b0}, 1'b0);
		xfer(8'h07, 8'h01, 1'b0);
		end_of_test();
	end
endmodule : tb_top
`default_nettype wire
